// file: verilog/cfs_consts.svh
// constants for the configuration status and remote update block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

// register byte offsets
`define CFS_OFF_CTRL      8'h00
`define CFS_OFF_APP_ADDR  8'h04
`define CFS_OFF_CAUSE     8'h08
`define CFS_OFF_STATUS    8'h0c
`define CFS_OFF_BOOT_ADDR 8'h10
`define CFS_OFF_FACT_ADDR 8'h14

// control register fields
`define CFS_CTRL_RECONFIG 0

// cause register fields
`define CFS_CAUSE_STATUS_LOW 0
`define CFS_CAUSE_CRC        1
`define CFS_CAUSE_WATCHDOG   2
`define CFS_CAUSE_CFG_RESET  3
`define CFS_CAUSE_W          4

// status register fields
`define CFS_STAT_USER      0
`define CFS_STAT_INIT_LOW  1
`define CFS_STAT_REMOTE    2
`define CFS_STAT_FACTORY   3
`define CFS_STAT_CAL_DONE  4
`define CFS_STAT_STATE_LSB 8

// scheme select encodings
`define CFS_SCHEME_W      3
`define CFS_SCHEME_AS     3'h2
`define CFS_SCHEME_AP     3'h4

// boot addresses
`define CFS_ADDR_W        24
`define CFS_AS_BOOT_ADDR  24'h000000
`define CFS_AP_BOOT_RESET 24'h010000

`endif

// file: verilog/cfs_pkg.sv
// types for the configuration status and remote update block
// assumes cfs_consts.svh is on the include path
`include "cfs_consts.svh"

package cfs_pkg;

   // configuration sequence, one-hot
   typedef enum logic [3:0] {
      CFS_ST_IDLE = 4'h1,   // config request held low
      CFS_ST_OPTS = 4'h2,   // loading, waiting for first frame options
      CFS_ST_INIT = 4'h4,   // initializing
      CFS_ST_USER = 4'h8    // user mode
   } cfs_state_e;

   // whole state of the top module
   typedef struct packed {
      cfs_state_e                 state;
      logic                       init_en;
      logic                       oct_gate;
      logic                       remote_en;
      logic                       factory;
      logic [`CFS_ADDR_W-1:0]     app_addr;
      logic [`CFS_ADDR_W-1:0]     fact_addr;
      logic [`CFS_ADDR_W-1:0]     boot_addr;
      logic [`CFS_CAUSE_W-1:0]    cause;
      logic                       reconfig;
      logic                       ack;
      logic [31:0]                rdata;
   } cfs_top_s;

endpackage : cfs_pkg

// file: verilog/cfs_sync.sv
// two flip-flop level synchronizer, one per bit
// assumes levels that change slowly against clk_i
`timescale 1ns/1ps
`default_nettype none

module cfs_sync #(
   parameter int            W      = 1,
   parameter logic [W-1:0]  RST_V  = '0
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [W-1:0]  d_i,
   output logic      [W-1:0]  q_o
);

   // both stages of every bit
   typedef struct packed {
      logic [W-1:0] s1;   // first stage, read only by s2
      logic [W-1:0] s2;   // stable stage
   } cfs_sync_s;

   cfs_sync_s st_q;
   cfs_sync_s st_d;

   // refuse widths that the stages cannot hold
   if (W < 1) begin : g_bad_width
      $error("cfs_sync: W must be at least 1");
   end

   // next state: shift one stage
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   // registers, synchronous reset to the idle level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= {RST_V, RST_V};
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.s2;

endmodule : cfs_sync

`default_nettype wire

// file: verilog/cfs_top.sv
// configuration status pins and remote update control
// assumes inputs synchronous to clk_i except the two global overrides
//
// Notes on behaviour
// - config request low: status pin released
// - first-frame option received: drive pin low
// - init finished: release pin, enter user
// - optional gate on termination calibration done
// - output enable low tristates all pins (here io_tristate_o only; the status pin is not released)
// - clear low clears all registers (here core_clear_o only; the registers of this block keep their values)
// - remote update only in active schemes
// - no remote update in device chain
// - detect, recover errors, report status
// - same scheme select; standard disables circuitry
// - remote behaviour needs remote option bit
// - factory image is fall-back, administers updates
// - remote update works with decompression
// - serial scheme boots factory at zero
// - parallel scheme boots factory at register
// - cause written on status, crc, watchdog, reset
// - any error reloads the factory image
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "cfs_consts.svh"

module cfs_top (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // classic wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // configuration sequence inputs
   input  wire logic                       config_request_n_i,
   input  wire logic                       opt_valid_i,
   input  wire logic                       opt_init_done_en_i,
   input  wire logic                       opt_oct_gate_i,
   input  wire logic                       opt_remote_en_i,
   input  wire logic                       init_complete_i,
   input  wire logic                       termination_cal_done_i,
   input  wire logic [`CFS_SCHEME_W-1:0]   scheme_select_i,
   input  wire logic                       multi_device_chain_i,
   input  wire logic                       decompress_en_i,
   input  wire logic                       crc_error_i,
   input  wire logic                       watchdog_timeout_i,
   input  wire logic                       config_status_n_i,
   // global overrides, asynchronous
   input  wire logic                       global_output_enable_i,
   input  wire logic                       global_clear_n_i,
   // open-drain status pin
   output logic                            init_done_o,
   output logic                            init_done_oe_n_o,
   // core controls
   output logic                            io_tristate_o,
   output logic                            core_clear_o,
   output logic                            user_mode_o,
   output logic                            reconfig_o,
   output logic      [`CFS_ADDR_W-1:0]     boot_address_o,
   output logic                            remote_avail_o
);

   cfs_pkg::cfs_top_s st_q;       // registered state
   cfs_pkg::cfs_top_s st_d;       // next state
   logic [1:0]        ovr_sync;   // synchronized oe and clear_n
   logic              scheme_ok;  // active serial or active parallel
   logic              remote_ok;  // remote circuitry enabled
   logic              active;     // loading or running
   logic              init_go;    // initialization finished
   logic              err_crc;    // crc error while active
   logic              err_stat;   // status pin pulled low externally
   logic              err_wdt;    // watchdog expiry in user mode
   logic              err_any;    // any reconfiguring error
   logic              cfg_reset;  // config request while active
   logic              bus_req;    // request seen, not yet answered
   logic              wr_go;      // write takes effect this edge
   logic [31:0]       rd_mux;     // read data selected by address
   logic [`CFS_ADDR_W-1:0] fact_boot; // factory address per scheme
   logic              trig;       // software reconfiguration request
   logic [`CFS_CAUSE_W-1:0] cause_set; // events recorded this cycle
   logic [31:0]       app_mrg;    // app address word after lane merge
   logic [31:0]       fact_mrg;   // factory address word after lane merge

   // byte-lane merge for writable words
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
      end
      return r;
   endfunction : merge_lanes

   // override inputs through two flops each, released level is high
   cfs_sync #(
      .W     (2),
      .RST_V (2'h3)
   ) u_ovr_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({global_clear_n_i, global_output_enable_i}),
      .q_o   (ovr_sync)
   );

   // decode of scheme, chain and option bit
   always_comb begin
      scheme_ok = (scheme_select_i == `CFS_SCHEME_AS) ||
                  (scheme_select_i == `CFS_SCHEME_AP);
      // decompression does not take part: serial with it stays eligible
      remote_ok = scheme_ok && !multi_device_chain_i && st_q.remote_en;
      // factory start address depends on the scheme
      if (scheme_select_i == `CFS_SCHEME_AP) begin
         fact_boot = st_q.fact_addr;
      end else begin
         fact_boot = `CFS_AS_BOOT_ADDR;
      end
   end

   // error and completion events
   always_comb begin
      active    = (st_q.state != cfs_pkg::CFS_ST_IDLE);
      init_go   = init_complete_i &&
                  (!st_q.oct_gate || termination_cal_done_i);
      err_crc   = active && crc_error_i;
      err_stat  = active && !config_status_n_i;
      err_wdt   = (st_q.state == cfs_pkg::CFS_ST_USER) && watchdog_timeout_i;
      err_any   = err_crc || err_stat || err_wdt;
      cfg_reset = active && !config_request_n_i;
      cause_set = '0;
      cause_set[`CFS_CAUSE_STATUS_LOW] = err_stat;
      cause_set[`CFS_CAUSE_CRC]        = err_crc;
      cause_set[`CFS_CAUSE_WATCHDOG]   = err_wdt;
      cause_set[`CFS_CAUSE_CFG_RESET]  = cfg_reset;
   end

   // bus decode: write lands on the edge that ack is sampled
   always_comb begin
      bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
      wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack;
      trig    = wr_go && (wb_adr_i == `CFS_OFF_CTRL) && wb_sel_i[0] &&
                wb_dat_i[`CFS_CTRL_RECONFIG];
      // merged words, the top byte is dropped when stored
      app_mrg  = merge_lanes({8'h00, st_q.app_addr}, wb_dat_i, wb_sel_i);
      fact_mrg = merge_lanes({8'h00, st_q.fact_addr}, wb_dat_i, wb_sel_i);
   end

   // read data mux, unmapped words read zero
   always_comb begin
      rd_mux = '0;
      case (wb_adr_i)
         `CFS_OFF_APP_ADDR:  rd_mux[`CFS_ADDR_W-1:0] = st_q.app_addr;
         `CFS_OFF_CAUSE:     rd_mux[`CFS_CAUSE_W-1:0] = st_q.cause;
         `CFS_OFF_STATUS: begin
            rd_mux[`CFS_STAT_USER]     = (st_q.state == cfs_pkg::CFS_ST_USER);
            rd_mux[`CFS_STAT_INIT_LOW] = !init_done_oe_n_o;
            rd_mux[`CFS_STAT_REMOTE]   = remote_ok;
            rd_mux[`CFS_STAT_FACTORY]  = st_q.factory;
            rd_mux[`CFS_STAT_CAL_DONE] = termination_cal_done_i;
            rd_mux[`CFS_STAT_STATE_LSB +: 4] = st_q.state;
         end
         `CFS_OFF_BOOT_ADDR: rd_mux[`CFS_ADDR_W-1:0] = st_q.boot_addr;
         `CFS_OFF_FACT_ADDR: rd_mux[`CFS_ADDR_W-1:0] = st_q.fact_addr;
         default:            rd_mux = '0;
      endcase
   end

   // next state of the whole block
   always_comb begin
      st_d          = st_q;
      st_d.reconfig = 1'b0;
      st_d.ack      = bus_req;
      if (bus_req) begin
         st_d.rdata = rd_mux;
      end
      // register writes
      if (wr_go) begin
         case (wb_adr_i)
            `CFS_OFF_APP_ADDR:
               st_d.app_addr = app_mrg[`CFS_ADDR_W-1:0];
            `CFS_OFF_FACT_ADDR:
               st_d.fact_addr = fact_mrg[`CFS_ADDR_W-1:0];
            `CFS_OFF_CAUSE: begin
               if (wb_sel_i[0]) begin
                  st_d.cause = st_q.cause & ~wb_dat_i[`CFS_CAUSE_W-1:0];
               end
            end
            default: ;
         endcase
      end
      // hardware events overwrite the cause, set wins over clear
      if (remote_ok && (cause_set != '0)) begin
         st_d.cause = cause_set;
      end
      // sequence
      case (st_q.state)
         cfs_pkg::CFS_ST_IDLE: begin
            // pin released while request low
            if (config_request_n_i) begin
               st_d.state     = cfs_pkg::CFS_ST_OPTS;
               st_d.boot_addr = fact_boot;
               st_d.factory   = 1'b1;
            end
         end
         cfs_pkg::CFS_ST_OPTS: begin
            // first frame carries the option bits
            if (opt_valid_i) begin
               st_d.init_en   = opt_init_done_en_i;
               st_d.oct_gate  = opt_oct_gate_i;
               st_d.remote_en = opt_remote_en_i;
               st_d.state     = cfs_pkg::CFS_ST_INIT;
            end
         end
         cfs_pkg::CFS_ST_INIT: begin
            // release and enter user mode together
            if (init_go) begin
               st_d.state = cfs_pkg::CFS_ST_USER;
            end
         end
         cfs_pkg::CFS_ST_USER: begin
            // user logic asks for an application image
            if (trig && remote_ok) begin
               st_d.state     = cfs_pkg::CFS_ST_OPTS;
               st_d.boot_addr = st_q.app_addr;
               st_d.factory   = 1'b0;
               st_d.reconfig  = 1'b1;
            end
         end
         default: st_d.state = cfs_pkg::CFS_ST_IDLE;
      endcase
      // errors restart from the factory image
      if (err_any && remote_ok) begin
         st_d.state     = cfs_pkg::CFS_ST_OPTS;
         st_d.boot_addr = fact_boot;
         st_d.factory   = 1'b1;
         st_d.reconfig  = 1'b1;
      end else if (err_any) begin
         // standard mode simply restarts configuration
         st_d.state     = cfs_pkg::CFS_ST_OPTS;
         st_d.boot_addr = fact_boot;
      end
      // request low wins over every other choice of next state
      if (!config_request_n_i) begin
         st_d.state   = cfs_pkg::CFS_ST_IDLE;
         st_d.init_en = 1'b0;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q           <= '0;
         st_q.state     <= cfs_pkg::CFS_ST_IDLE;
         st_q.fact_addr <= `CFS_AP_BOOT_RESET;
         st_q.factory   <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs
   always_comb begin
      init_done_o      = 1'b0;
      // pin pulled low only while initializing with the option on
      init_done_oe_n_o = !((st_q.state == cfs_pkg::CFS_ST_INIT) &&
                           st_q.init_en);
      io_tristate_o    = !ovr_sync[0];
      core_clear_o     = !ovr_sync[1];
      user_mode_o      = (st_q.state == cfs_pkg::CFS_ST_USER);
      reconfig_o       = st_q.reconfig;
      boot_address_o   = st_q.boot_addr;
      remote_avail_o   = remote_ok;
      wb_dat_o         = st_q.rdata;
      wb_ack_o         = st_q.ack;
   end

   // checks on the sequence, the bus triggers and the overrides
   a_init_released: assert property (@(posedge clk_i) disable iff (rst_i)
      !config_request_n_i |=> init_done_oe_n_o)
      else $error("status pin driven while config request low");

   a_init_driven: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.state == cfs_pkg::CFS_ST_OPTS) && opt_valid_i && opt_init_done_en_i
      && config_request_n_i && !err_any |=> !init_done_oe_n_o)
      else $error("status pin not driven after option bit");

   a_user_released: assert property (@(posedge clk_i) disable iff (rst_i)
      user_mode_o |-> init_done_oe_n_o)
      else $error("status pin driven in user mode");

   a_oct_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(user_mode_o) |-> $past(termination_cal_done_i) ||
                             !$past(st_q.oct_gate))
      else $error("user mode entered before calibration done");

   a_oe_override: assert property (@(posedge clk_i) disable iff (rst_i)
      !global_output_enable_i [*3] |=> io_tristate_o)
      else $error("pins not tristated under override");

   a_clr_override: assert property (@(posedge clk_i) disable iff (rst_i)
      global_clear_n_i [*3] |=> !core_clear_o)
      else $error("clear held without override");

   a_std_no_trig: assert property (@(posedge clk_i) disable iff (rst_i)
      trig && !remote_ok && !err_any |=> !reconfig_o)
      else $error("reconfiguration started in standard mode");

   // a software trigger in user mode loads the stored application address
   a_trig_app: assert property (@(posedge clk_i) disable iff (rst_i)
      trig && remote_ok && user_mode_o && !err_any && config_request_n_i |=>
         reconfig_o && !st_q.factory && (boot_address_o == $past(st_q.app_addr)))
      else $error("trigger did not load the application image");

   a_err_factory: assert property (@(posedge clk_i) disable iff (rst_i)
      err_any && remote_ok && config_request_n_i |=>
         reconfig_o && st_q.factory && (boot_address_o == $past(fact_boot))
         && (st_q.cause == $past(cause_set)))
      else $error("error did not reload factory image");

   a_as_boot: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.state == cfs_pkg::CFS_ST_IDLE) && config_request_n_i &&
      (scheme_select_i == `CFS_SCHEME_AS) |=>
         boot_address_o == `CFS_AS_BOOT_ADDR)
      else $error("serial factory boot address not zero");

endmodule : cfs_top

`default_nettype wire

// file: verification/cfs_board_model.sv
// board side of the status pin: pull-up and a rising-edge monitor
// assumes the pin is driven only through the open-drain pair of cfs_top
`timescale 1ns/1ps
`default_nettype none

module cfs_board_model (
   input  wire logic        clk_i,
   input  wire logic        init_done_i,
   input  wire logic        init_done_oe_n_i,
   output logic             pin_o,
   output logic [7:0]       rises_o
);
   logic       pin_q = 1'b1;    // pin level at the last edge
   logic [7:0] rises_q = 8'h00; // rising edges seen so far

   // pull-up wins whenever the device lets go of the pin
   assign pin_o = init_done_oe_n_i ? 1'b1 : init_done_i;
   assign rises_o = rises_q;

   // the monitor counts low-to-high moves as the device going operational
   always @(posedge clk_i) begin
      if (pin_o && !pin_q) begin
         rises_q <= rises_q + 8'h01;
      end
      pin_q <= pin_o;
   end
endmodule : cfs_board_model
`default_nettype wire

// file: verification/cfs_top_tb.sv
// self-checking bench for the status pins and remote update control
// assumes cfs_consts.svh on the include path and the board model beside it
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"

module cfs_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic        ack, req_n = 1'b0, opt_v = 1'b0, opt_init = 1'b0, opt_gate = 1'b0;
   logic        opt_rem = 1'b0, init_c = 1'b0, cal = 1'b0, chain = 1'b0, dec = 1'b1;
   logic        crc = 1'b0, wdog = 1'b0, stat_n = 1'b1, goe = 1'b1, gclr_n = 1'b1;
   logic [2:0]  sch = `CFS_SCHEME_AS;
   logic        init_done, oe_n, tri_o, clr_o, user, recfg, avail, pin;
   logic [23:0] boot;
   logic [7:0]  rises;
   int          fails = 0, compares = 0, recfgs = 0, n;

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   // count reconfiguration pulses
   always @(posedge clk_i) begin
      if (recfg === 1'b1) begin
         recfgs++;
      end
   end

   cfs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .config_request_n_i(req_n), .opt_valid_i(opt_v), .opt_init_done_en_i(opt_init),
      .opt_oct_gate_i(opt_gate), .opt_remote_en_i(opt_rem), .init_complete_i(init_c),
      .termination_cal_done_i(cal), .scheme_select_i(sch), .multi_device_chain_i(chain),
      .decompress_en_i(dec), .crc_error_i(crc), .watchdog_timeout_i(wdog),
      .config_status_n_i(stat_n), .global_output_enable_i(goe), .global_clear_n_i(gclr_n),
      .init_done_o(init_done), .init_done_oe_n_o(oe_n), .io_tristate_o(tri_o),
      .core_clear_o(clr_o), .user_mode_o(user), .reconfig_o(recfg),
      .boot_address_o(boot), .remote_avail_o(avail));

   cfs_board_model board (.clk_i(clk_i), .init_done_i(init_done),
      .init_done_oe_n_i(oe_n), .pin_o(pin), .rises_o(rises));

   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask : tick

   // compare a 32-bit value
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk32

   // compare a single bit
   task automatic chk1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   // one classic wishbone cycle; read data lands in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) begin
         fails++;
         $display("unexpected ack: expected 1 seen %b", ack);
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // restart and walk the sequence up to initialization finished
   task automatic boot_run(input logic [2:0] s, input logic gate);
      req_n <= 1'b0;
      init_c <= 1'b0;
      sch <= s;
      tick(2);
      chk1("pin at request", 1'b1, pin);
      req_n <= 1'b1;
      tick(2);
      opt_v <= 1'b1;
      opt_init <= 1'b1;
      opt_gate <= gate;
      opt_rem <= 1'b1;
      tick(1);
      opt_v <= 1'b0;
      tick(2);
      chk1("pin while init", 1'b0, pin);
      init_c <= 1'b1;
      tick(3);
   endtask : boot_run

   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // hang guard, far beyond the roughly 140 cycles the tests need
   initial begin
      tick(5000);
      fails++;
      summarize();
   end

   initial begin
      tick(2);
      rst_i <= 1'b0;
      tick(1);
      chk1("pin after reset", 1'b1, pin);
      chk1("tristate after reset", 1'b0, tri_o);
      chk1("user after reset", 1'b0, user);
      wb(1'b0, `CFS_OFF_FACT_ADDR, 32'h0);
      chk32("factory addr", 32'h00010000, rd);
      wb(1'b0, 8'h40, 32'h0);
      chk32("unmapped read", 32'h0, rd);
      $display("test reset done");
      // serial scheme, indication gated on calibration
      boot_run(`CFS_SCHEME_AS, 1'b1);
      chk1("user before cal", 1'b0, user);
      chk1("pin before cal", 1'b0, pin);
      cal <= 1'b1;
      tick(3);
      chk1("user mode", 1'b1, user);
      chk32("pin rises", 32'h1, {24'h0, rises});
      chk1("remote avail", 1'b1, avail);
      chk32("serial boot", 32'h0, {8'h0, boot});
      $display("test serial boot done");
      // user logic stores an image location then triggers
      wb(1'b1, `CFS_OFF_APP_ADDR, 32'h00123456);
      n = recfgs;
      wb(1'b1, `CFS_OFF_CTRL, 32'h1);
      tick(2);
      chk32("trigger pulses", 32'(n + 1), 32'(recfgs));
      chk32("app boot", 32'h00123456, {8'h0, boot});
      $display("test trigger done");
      // parallel scheme: each error reloads the factory image
      wb(1'b1, `CFS_OFF_FACT_ADDR, 32'h00abcdef);
      cal <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         boot_run(`CFS_SCHEME_AP, 1'b0);
         chk1("user without gate", 1'b1, user);
         chk32("parallel boot", 32'h00abcdef, {8'h0, boot});
         if (k > 0) begin
            wb(1'b0, `CFS_OFF_CAUSE, 32'h0);
            chk32("reset cause", 32'h8, rd);
         end
         n = recfgs;
         stat_n <= (k != 0);
         crc <= (k == 1);
         wdog <= (k == 2);
         tick(1);
         stat_n <= 1'b1;
         crc <= 1'b0;
         wdog <= 1'b0;
         tick(2);
         chk32("error pulses", 32'(n + 1), 32'(recfgs));
         chk32("fallback boot", 32'h00abcdef, {8'h0, boot});
         wb(1'b0, `CFS_OFF_CAUSE, 32'h0);
         chk32("error cause", 32'(1 << k), rd);
         wb(1'b0, `CFS_OFF_STATUS, 32'h0);
         chk1("factory flag", 1'b1, rd[`CFS_STAT_FACTORY]);
         wb(1'b1, `CFS_OFF_CAUSE, 32'(1 << k));
         wb(1'b0, `CFS_OFF_CAUSE, 32'h0);
         chk32("cause cleared", 32'h0, rd);
      end
      $display("test errors done");
      // chain and other schemes switch the upgrade off
      chain <= 1'b1;
      tick(2);
      chk1("avail in chain", 1'b0, avail);
      chain <= 1'b0;
      boot_run(3'h0, 1'b0);
      chk1("user other scheme", 1'b1, user);
      chk1("avail other scheme", 1'b0, avail);
      n = recfgs;
      wb(1'b1, `CFS_OFF_CTRL, 32'h1);
      tick(2);
      chk32("standard trigger", 32'(n), 32'(recfgs));
      chk32("standard boot", 32'h0, {8'h0, boot});
      sch <= `CFS_SCHEME_AP;
      $display("test availability done");
      // global overrides pass two synchronizer stages
      goe <= 1'b0;
      gclr_n <= 1'b0;
      tick(1);
      chk1("tristate early", 1'b0, tri_o);
      tick(2);
      chk1("tristate", 1'b1, tri_o);
      chk1("clear", 1'b1, clr_o);
      goe <= 1'b1;
      gclr_n <= 1'b1;
      tick(3);
      chk1("tristate off", 1'b0, tri_o);
      chk1("clear off", 1'b0, clr_o);
      $display("test overrides done");
      summarize();
   end
endmodule : cfs_top_tb
`default_nettype wire
